// ---- shared/emlg_pkg.sv ----
// Purpose: Shared constants and carriers for the embedded metadata line generator
// Assumes: 8-bit register port, RAW12 packing of embedded lines
// Notes: Status register offset and length reset value are local choices
package emlg_pkg;
    // Register offsets
    localparam logic [15:0] LEN_HIGH_ADDR = 16'h2c0c;
    localparam logic [15:0] LEN_LOW_ADDR = 16'h2c0d;
    localparam logic [15:0] LINE_SEL_ADDR = 16'h3c18;
    localparam logic [15:0] STATUS_ADDR = 16'h3c19;
    // Reset values (length defaults to the bare 132 values)
    localparam logic [7:0] LEN_HIGH_RESET = 8'h10;
    localparam logic [2:0] LEN_LOW_RESET = 3'h4;
    localparam logic [1:0] LINE_SEL_RESET = 2'h2;
    // Field positions
    localparam int LEN_LOW_LSB = 5;
    // Line select encodings
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_ONE = 2'h1;
    localparam logic [1:0] SEL_TWO = 2'h2;
    // Line content
    localparam logic [10:0] EMB_VALUES = 11'h084;
    localparam logic [10:0] EOD_FIRST = 11'h07f;
    localparam logic [7:0] DATA_TYPE = 8'h0a;
    localparam logic [7:0] END_DATA = 8'h07;
    localparam logic [7:0] DUMMY_BYTE = 8'h55;
    localparam logic [7:0] PAD_PIXEL = 8'h07;
    // Tag codes
    localparam logic [7:0] TAG_IDX_MSB = 8'haa;
    localparam logic [7:0] TAG_IDX_LSB = 8'ha5;
    localparam logic [7:0] TAG_VALID = 8'h5a;
    localparam logic [7:0] TAG_NULL = 8'h55;

    // Sensor settings reported on line one
    typedef struct packed {
        logic vflip;
        logic hmirror;
        logic [7:0] user_tag;
        logic [7:0] out_mode;
        logic four_lanes;
        logic [7:0] binning;
        logic [7:0] divider;
        logic [7:0] predivider;
        logic [7:0] temp;
    } emlg_info_s;

    // Statistics reported on line two
    typedef struct packed {
        logic [19:0] low_total;
        logic [19:0] high_total;
        logic [7:0] frame;
        logic [7:0] phase;
    } emlg_stat_s;

    // One beat towards the lane packetisers
    typedef struct packed {
        logic [3:0][7:0] data;
        logic [3:0] valid;
        logic sop;
        logic eop;
    } emlg_lanes_s;
endpackage

// ---- core/emlg_top.sv ----
// Purpose: Build the embedded metadata lines after each phase image
// Assumes: Pixel and control inputs share core_clk; byte clock is foreign
// Notes: One beat per byte-clock rising edge, one byte per active lane
// Operation
// - Lines follow last pixel row, two maximum
// - Select 00 none, 01 one, 10 both
// - Each line holds 132 embedded values
// - Length is high byte plus three bits
// - Beyond 132, pad with dummy pixels
// - Programmed length equals pixels sent
// - First value is always 0x0A
// - Line one flip, mirror, tag, mode, lanes
// - Line one binning, divider, predivider
// - E078 temperature high, low nibble 0101
// - E127 to E131 carry 0x07
// - Line two limit totals, high part first
// - Line two frame and phase numbers
// - Two values then dummy 0x55
// - Odd positions carry tag bytes
// - Tags 0xAA, 0xA5 mark index bytes
// - Tag 0x5A marks valid data
// - Tag 0x55 marks null data 0x07
// - Four lanes get bytes round robin
// - Two lanes alternate, E000 on one
// - Totals count pixels outside thresholds
`timescale 1ns/1ns
module emlg_top #(
    parameter logic [15:0] REG_INDEX_BASE = 16'h0000 // Arbitrary first index
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Image timing and pixels
    input wire logic frame_start,
    input wire logic phase_start,
    input wire logic rows_done,
    input wire logic pix_valid,
    input wire logic [10:0] pix_data,
    input wire logic [10:0] lower_limit,
    input wire logic [10:0] upper_limit,
    input wire emlg_pkg::emlg_info_s info,
    // Output byte clock and lanes
    input wire logic link_clk,
    output emlg_pkg::emlg_lanes_s lanes
);
    // Idle waits for the row end; send covers both lines back to back
    typedef enum logic {ST_IDLE, ST_SEND} emlg_state_e;

    // Registers
    logic [7:0] len_high;
    logic [2:0] len_low;
    logic [1:0] line_sel;
    // Sequencing
    emlg_state_e state;
    logic second; // High while line two is going out
    logic [12:0] ptr; // Next byte index of the line
    // Statistics
    logic [19:0] run_low;
    logic [19:0] run_high;
    emlg_pkg::emlg_stat_s stat;
    // Byte clock synchroniser and edge finder
    logic lk_s1;
    logic lk_s2;
    logic lk_s3;

    // Length is read live: rewriting it mid-line cuts or stretches that line
    // Line length in pixels and in packed bytes
    wire logic [10:0] line_len = {len_high, len_low};
    wire logic [12:0] total_bytes = 13'(({2'h0, line_len} * 13'd3 + 13'd1) >> 1);
    wire logic [2:0] nlanes = info.four_lanes ? 3'd4 : 3'd2;
    // One beat per rising edge of the synchronised byte clock
    wire logic beat = lk_s2 & ~lk_s3;
    wire logic want_lines = (line_sel == emlg_pkg::SEL_ONE) || (line_sel == emlg_pkg::SEL_TWO);
    // A zero length or the unused select code never starts a line
    wire logic start_line = (state == ST_IDLE) && rows_done && want_lines && (line_len != 11'h0);
    // Last beat once this beat reaches the end of the packed line
    wire logic last_beat = ({1'b0, ptr} + {11'h0, nlanes}) >= {1'b0, total_bytes};
    wire logic send_beat = (state == ST_SEND) && beat;
    // A pixel equal to a limit is not a violation
    wire logic low_hit = pix_valid && (pix_data < lower_limit);
    wire logic high_hit = pix_valid && (pix_data > upper_limit);

    // Data byte of an even position; bit 8 says a field exists there
    function automatic logic [8:0] field_of(input logic two, input logic [10:0] p,
            input emlg_pkg::emlg_info_s i, input emlg_pkg::emlg_stat_s s);
        logic [8:0] f;
        f = 9'h000;
        // Line one carries settings, line two the statistics
        if (!two) begin
            case (p)
                11'd42: f = {1'b1, 7'h00, i.vflip};
                11'd44: f = {1'b1, 7'h00, i.hmirror};
                11'd58: f = {1'b1, i.user_tag};
                11'd62: f = {1'b1, i.out_mode};
                11'd68: f = {1'b1, 7'h00, i.four_lanes};
                // Low nibble 0101 rides in the shared 0x55 byte
                11'd78: f = {1'b1, i.temp};
                11'd82: f = {1'b1, i.binning};
                11'd96: f = {1'b1, i.divider};
                11'd98: f = {1'b1, i.predivider};
                default: f = 9'h000;
            endcase
        end else begin
            case (p)
                11'd50: f = {1'b1, 4'h0, s.low_total[19:16]};
                11'd52: f = {1'b1, s.low_total[15:8]};
                11'd54: f = {1'b1, s.low_total[7:0]};
                11'd58: f = {1'b1, 4'h0, s.high_total[19:16]};
                11'd60: f = {1'b1, s.high_total[15:8]};
                11'd62: f = {1'b1, s.high_total[7:0]};
                11'd90: f = {1'b1, s.frame};
                11'd96: f = {1'b1, s.phase};
                default: f = 9'h000;
            endcase
        end
        return f;
    endfunction

    // Value of embedded position p
    function automatic logic [7:0] emb_value(input logic two, input logic [10:0] p,
            input emlg_pkg::emlg_info_s i, input emlg_pkg::emlg_stat_s s);
        logic [7:0] v;
        logic [8:0] f;
        v = emlg_pkg::PAD_PIXEL;
        f = field_of(two, (p[0] ? p + 11'd1 : p), i, s);
        // Padding and end codes outrank every field, so test them first
        // The fixed index bytes sit ahead of the first tag of the walk
        if (p >= emlg_pkg::EMB_VALUES) begin
            v = emlg_pkg::PAD_PIXEL;
        end else if (p == 11'd0) begin
            v = emlg_pkg::DATA_TYPE;
        end else if (p >= emlg_pkg::EOD_FIRST) begin
            v = emlg_pkg::END_DATA;
        end else if (p == 11'd1) begin
            v = emlg_pkg::TAG_IDX_MSB;
        end else if (p == 11'd2) begin
            v = REG_INDEX_BASE[15:8];
        end else if (p == 11'd3) begin
            v = emlg_pkg::TAG_IDX_LSB;
        end else if (p == 11'd4) begin
            v = REG_INDEX_BASE[7:0];
        end else if (p[0]) begin
            // Tag for the next even slot; the index steps once per pair
            v = f[8] ? emlg_pkg::TAG_VALID : emlg_pkg::TAG_NULL;
        end else begin
            // Even slot: field value, or the null data code
            v = f[8] ? f[7:0] : emlg_pkg::END_DATA;
        end
        return v;
    endfunction

    // Byte b of the packed stream: every third byte is dummy
    function automatic logic [7:0] stream_byte(input logic two, input logic [12:0] b,
            input emlg_pkg::emlg_info_s i, input emlg_pkg::emlg_stat_s s);
        logic [12:0] p;
        // Dividers cost area; kept since the lane count varies at run time
        p = b - (b / 13'd3);
        if ((b % 13'd3) == 13'd2) begin
            return emlg_pkg::DUMMY_BYTE;
        end
        return emb_value(two, p[10:0], i, s);
    endfunction

    // Next beat: lane k carries byte ptr+k, round robin
    emlg_pkg::emlg_lanes_s next_lanes;
    always_comb begin
        // Unused lanes stay zero so a short last beat is easy to spot
        next_lanes = '0;
        for (int k = 0; k < 4; k++) begin
            if ((3'(k) < nlanes) && ((ptr + 13'(k)) < total_bytes)) begin
                next_lanes.valid[k] = 1'b1;
                next_lanes.data[k] = stream_byte(second, ptr + 13'(k), info, stat);
            end
        end
        next_lanes.sop = (ptr == 13'h0);
        next_lanes.eop = last_beat;
    end

    // Byte clock sampled into core_clk
    // Only lk_s2 and lk_s3 feed logic; lk_s1 may still be settling
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lk_s1 <= 1'b0;
            lk_s2 <= 1'b0;
            lk_s3 <= 1'b0;
        end else begin
            lk_s1 <= link_clk;
            lk_s2 <= lk_s1;
            lk_s3 <= lk_s2;
        end
    end

    // Register writes
    // Bits 4:0 of the low length byte are not stored
    // Unmapped addresses are ignored without any answer
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            len_high <= emlg_pkg::LEN_HIGH_RESET;
            len_low <= emlg_pkg::LEN_LOW_RESET;
            line_sel <= emlg_pkg::LINE_SEL_RESET;
        end else if (reg_wr) begin
            if (reg_addr == emlg_pkg::LEN_HIGH_ADDR) begin
                len_high <= reg_wdata;
            end
            if (reg_addr == emlg_pkg::LEN_LOW_ADDR) begin
                len_low <= reg_wdata[7:emlg_pkg::LEN_LOW_LSB];
            end
            if (reg_addr == emlg_pkg::LINE_SEL_ADDR) begin
                line_sel <= reg_wdata[1:0];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    // Status bit 0 is busy, bit 1 says line two is going out
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                emlg_pkg::LEN_HIGH_ADDR: reg_rdata <= len_high;
                emlg_pkg::LEN_LOW_ADDR: reg_rdata <= {len_low, 5'h00};
                emlg_pkg::LINE_SEL_ADDR: reg_rdata <= {6'h00, line_sel};
                emlg_pkg::STATUS_ADDR: reg_rdata <= {6'h00, second, state == ST_SEND};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Line sequencer; a new phase end during a line is ignored
    // Line two restarts ptr from zero; its lane count is read live from info.four_lanes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            second <= 1'b0;
            ptr <= 13'h0;
        end else if (start_line) begin
            state <= ST_SEND;
            second <= 1'b0;
            ptr <= 13'h0;
        end else if (send_beat) begin
            ptr <= last_beat ? 13'h0 : ptr + 13'(nlanes);
            if (last_beat && !second && (line_sel == emlg_pkg::SEL_TWO)) begin
                second <= 1'b1;
            end else if (last_beat) begin
                state <= ST_IDLE;
                second <= 1'b0;
            end
        end
    end

    // Lane outputs held only for the beat cycle
    // The receiver side must sample every core cycle to catch each beat
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lanes <= '0;
        end else if (send_beat) begin
            lanes <= next_lanes;
        end else begin
            lanes <= '0;
        end
    end

    // Threshold violation counters, saturating at 20 bits
    // Saturation keeps a flood of violations from wrapping to a small total
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            run_low <= 20'h0;
            run_high <= 20'h0;
        end else if (phase_start) begin
            run_low <= 20'h0;
            run_high <= 20'h0;
        end else begin
            if (low_hit && (run_low != 20'hfffff)) begin
                run_low <= run_low + 20'h1;
            end
            if (high_hit && (run_high != 20'hfffff)) begin
                run_high <= run_high + 20'h1;
            end
        end
    end

    // Frame and phase numbers, totals frozen at phase end
    // Totals latch only when idle, so a refused row end leaves them alone
    // The frame number wraps at eight bits
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stat <= '0;
        end else begin
            if (frame_start) begin
                stat.frame <= stat.frame + 8'h01;
                stat.phase <= 8'h00;
            end else if (phase_start) begin
                stat.phase <= stat.phase + 8'h01;
            end
            if (rows_done && (state == ST_IDLE)) begin
                stat.low_total <= run_low;
                stat.high_total <= run_high;
            end
        end
    end

    // Helper: bytes sent in the current line
    // Feeds only the byte count check below
    logic [12:0] sent;
    wire logic [2:0] beat_bytes = 3'(lanes.valid[0]) + 3'(lanes.valid[1])
        + 3'(lanes.valid[2]) + 3'(lanes.valid[3]);
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sent <= 13'h0;
        end else if (lanes.eop) begin
            sent <= 13'h0;
        end else begin
            sent <= sent + 13'(beat_bytes);
        end
    end

    // Sequencer, lane beat and statistics checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_no_lines_off: assert property ((state == ST_IDLE) && rows_done
        && (line_sel == emlg_pkg::SEL_NONE) |=> state == ST_IDLE)
        else $error("line started while disabled");
    a_line_starts: assert property (start_line |=> state == ST_SEND && !second)
        else $error("line did not start after rows");
    a_first_type: assert property (lanes.sop && !second |-> lanes.data[0] == 8'h0a
        && lanes.valid[0])
        else $error("first byte is not data type");
    a_first_tag: assert property (lanes.sop |-> lanes.data[1] == 8'haa)
        else $error("lane two first byte is not index tag");
    a_four_dummy: assert property (lanes.sop && lanes.valid[3] && lanes.valid[2]
        |-> lanes.data[2] == 8'h55)
        else $error("third byte is not dummy");
    a_byte_total: assert property (lanes.eop |-> 13'(sent + 13'(beat_bytes)) == total_bytes)
        else $error("line byte count mismatch");
    a_second_line: assert property (send_beat && last_beat && !second
        && (line_sel == emlg_pkg::SEL_TWO) |=> second && state == ST_SEND)
        else $error("second line missing");
    a_frame_step: assert property (frame_start |=> stat.frame == $past(stat.frame) + 8'h01
        && stat.phase == 8'h00)
        else $error("frame number did not step");
    a_total_latch: assert property (rows_done && state == ST_IDLE
        |=> stat.low_total == $past(run_low) && stat.high_total == $past(run_high))
        else $error("limit totals not latched");
    a_idle_quiet: assert property (state == ST_IDLE ##1 state == ST_IDLE |-> lanes.valid == 4'h0)
        else $error("lane data while idle");
    a_busy_refuse: assert property ((state == ST_SEND) && rows_done |=>
        $stable(stat.low_total) && $stable(stat.high_total))
        else $error("row end accepted during a line");
    a_beat_single: assert property (lanes.valid != 4'h0 |=> lanes.valid == 4'h0)
        else $error("lane beat held for two cycles");
    a_line_type: assert property (lanes.sop |-> lanes.data[0] == emlg_pkg::DATA_TYPE)
        else $error("line does not open with data type");

    // Main scenarios
    c_one_line: cover property (lanes.eop && !second && line_sel == emlg_pkg::SEL_ONE);
    c_two_lines: cover property (lanes.eop && second);
    c_four_lanes: cover property (lanes.sop && lanes.valid == 4'hf);
    c_padded: cover property (lanes.eop && line_len > emlg_pkg::EMB_VALUES);
    c_refused: cover property (rows_done && state == ST_SEND);
endmodule

// ---- test/emlg_rx_model.sv ----
// Purpose: Receiver model that rebuilds each embedded line from lane beats
// Assumes: A beat is one core_clk cycle; valid lanes are taken in order 0..3
// Notes: Keeps up to 1024 bytes of the line so the bench can compare it byte by byte
`timescale 1ns/1ns
module emlg_rx_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Lanes from the generator
    input wire emlg_pkg::emlg_lanes_s lanes,
    // Line report, one cycle after the closing beat
    output logic ln_ev,
    output int nbytes,
    output int eod_pos
);
    logic [7:0] buf_q [0:1023]; // Bytes of the current line
    int cnt; // Bytes gathered so far
    logic done; // End of data already seen
    // Gather bytes lane by lane; sop restarts the line
    always @(posedge core_clk) begin
        ln_ev <= 1'b0;
        if (!rst_b) begin
            cnt = 0;
            done = 1'b0;
        end else if (lanes.valid != 4'h0) begin
            if (lanes.sop) begin
                cnt = 0;
                done = 1'b0;
                eod_pos <= -1;
            end
            for (int i = 0; i < 4; i++) begin
                if (lanes.valid[i] && cnt < 1024) begin
                    buf_q[cnt] = lanes.data[i];
                    // Tag bytes sit at b%3==1; any end code stops parsing
                    if (!done && cnt % 3 == 1 && lanes.data[i] inside {8'h07, 8'h00, 8'hff}) begin
                        done = 1'b1;
                        eod_pos <= cnt - cnt / 3;
                    end
                    cnt++;
                end
            end
            nbytes <= cnt;
            ln_ev <= lanes.eop;
        end
    end
endmodule

// ---- test/tb_emlg_top.sv ----
// Purpose: Self-checking bench for the embedded metadata line generator
// Assumes: Byte clock free running at 800 ns, unrelated to core_clk
// Notes: Driver queues expected bytes; a watcher compares each line report
`timescale 1ns/1ns
module tb_emlg_top;
    logic core_clk, rst_b, reg_wr, reg_rd, frame_start, phase_start, rows_done, pix_valid;
    logic link_clk, ln_ev, rd_chk, rd_seen;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, frm, phs;
    logic [10:0] pix_data, lower_limit, upper_limit, lo, hi, pv, len;
    logic [19:0] low_t, high_t;
    logic [63:0] rv;
    logic [1:0] sel;
    emlg_pkg::emlg_info_s info, ival;
    emlg_pkg::emlg_lanes_s lanes;
    int nbytes, eod_pos, failures, check_count, seed, k, nl;
    logic [7:0] px_q [$]; // Expected line bytes
    int len_q [$]; // Expected bytes per line
    logic [7:0] rd_q [$]; // Expected read data

    emlg_top uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_start(frame_start), .phase_start(phase_start), .rows_done(rows_done),
        .pix_valid(pix_valid), .pix_data(pix_data), .lower_limit(lower_limit),
        .upper_limit(upper_limit), .info(info), .link_clk(link_clk), .lanes(lanes));
    emlg_rx_model mdl (.core_clk(core_clk), .rst_b(rst_b), .lanes(lanes), .ln_ev(ln_ev),
        .nbytes(nbytes), .eod_pos(eod_pos));

    // Core clock, 100 ns
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Byte clock, 800 ns, odd offset so the phases never line up
    initial begin
        link_clk = 1'b0;
        #137;
        forever #400 link_clk = ~link_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One write cycle, then an idle cycle so strobes never clash
    task automatic reg_write(input logic [15:0] a, input logic [7:0] wd);
        reg_addr <= a;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    // Read; a checked read leaves its expectation for the watcher
    task automatic reg_read(input logic [15:0] a, input logic chk, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_chk <= chk;
        if (chk)
            rd_q.push_back(exp);
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask

    // Field at pixel p, as {present, value}
    function automatic logic [8:0] fld(input int ln, input int p);
        if (p == 0) return {1'b1, 8'h0a};
        if (p == 2 || p == 4) return {1'b1, 8'h00};
        if (ln == 1) begin
            case (p)
                42: return {1'b1, 7'h00, info.vflip};
                44: return {1'b1, 7'h00, info.hmirror};
                58: return {1'b1, info.user_tag};
                62: return {1'b1, info.out_mode};
                68: return {1'b1, 7'h00, info.four_lanes};
                78: return {1'b1, info.temp};
                82: return {1'b1, info.binning};
                96: return {1'b1, info.divider};
                98: return {1'b1, info.predivider};
                default: return 9'h007;
            endcase
        end
        case (p)
            50: return {5'h10, low_t[19:16]};
            52: return {1'b1, low_t[15:8]};
            54: return {1'b1, low_t[7:0]};
            58: return {5'h10, high_t[19:16]};
            60: return {1'b1, high_t[15:8]};
            62: return {1'b1, high_t[7:0]};
            90: return {1'b1, frm};
            96: return {1'b1, phs};
            default: return 9'h007;
        endcase
    endfunction

    // Expected byte b of the packed stream of line ln
    function automatic logic [7:0] exp_byte(input int ln, input int b);
        int p;
        logic [8:0] f, g;
        p = b - b / 3;
        f = fld(ln, p + 1);
        g = fld(ln, p);
        if (b % 3 == 2) return 8'h55;
        if (p == 1) return 8'haa;
        if (p == 3) return 8'ha5;
        if (p % 2 == 0) return g[7:0];
        if (p < 127 && f[8]) return 8'h5a;
        if (p < 127) return 8'h55;
        return 8'h07;
    endfunction

    // Read watcher: data stands in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rd_seen && rd_q.size() > 0)
            check("read data", reg_rdata, rd_q.pop_front());
        rd_seen <= reg_rd && rd_chk;
    end

    // Line watcher: compare every byte the receiver gathered
    always @(posedge core_clk) begin
        if (ln_ev) begin
            if (len_q.size() == 0) begin
                check("unexpected line", 1, 0);
            end else begin
                check("line bytes", nbytes, len_q.pop_front());
                check("end of data", eod_pos, 127);
                for (int i = 0; i < nbytes && px_q.size() > 0; i++)
                    check($sformatf("byte %0d", i), mdl.buf_q[i], px_q.pop_front());
            end
        end
    end

    // Watchdog against a hung run
    initial begin
        repeat (100000) @(posedge core_clk);
        check("watchdog", 1, 0);
        give_verdict();
    end

    initial begin
        seed = 14883;
        {rst_b, reg_wr, reg_rd, frame_start, phase_start, rows_done, pix_valid} = 7'h00;
        {reg_addr, reg_wdata, rd_chk, pix_data, lower_limit, upper_limit} = '0;
        info = '0;
        {failures, check_count, frm, phs} = '0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        // Reset values and an unmapped place
        reg_read(emlg_pkg::LEN_HIGH_ADDR, 1, 8'h10);
        reg_read(emlg_pkg::LEN_LOW_ADDR, 1, 8'h80);
        reg_read(emlg_pkg::LINE_SEL_ADDR, 1, 8'h02);
        reg_read(16'h1234, 1, 8'h00);
        // Select codes 00, 01 and 10, both lane counts, several lengths
        for (int r = 0; r < 6; r++) begin
            sel = 2'(r % 3);
            len = (r == 0) ? 11'd132 : (r % 2) ? 11'd320 : 11'd133 + 11'($unsigned($random(seed)) % 200);
            rv = {$random(seed), $random(seed)};
            reg_write(emlg_pkg::LEN_HIGH_ADDR, len[10:3]);
            reg_write(emlg_pkg::LEN_LOW_ADDR, {len[2:0], rv[4:0]});
            reg_read(emlg_pkg::LEN_LOW_ADDR, 1, {len[2:0], 5'h00});
            reg_write(emlg_pkg::LINE_SEL_ADDR, {6'h00, sel});
            reg_read(emlg_pkg::LINE_SEL_ADDR, 1, {6'h00, sel});
            if (r % 2 == 0) begin
                frame_start <= 1'b1;
                @(posedge core_clk);
                frame_start <= 1'b0;
                frm = frm + 8'h01;
                phs = 8'h00;
            end
            ival = rv[50:0];
            ival.four_lanes = (r >= 3);
            lo = rv[61:51];
            hi = lo + 11'($unsigned($random(seed)) % 600);
            info <= ival;
            lower_limit <= lo;
            upper_limit <= hi;
            phase_start <= 1'b1;
            @(posedge core_clk);
            phase_start <= 1'b0;
            phs = phs + 8'h01;
            {low_t, high_t} = '0;
            // Pixels of the phase, counted against the limits
            repeat (40) begin
                pv = 11'($random(seed));
                pix_data <= pv;
                pix_valid <= 1'b1;
                if (pv < lo) low_t++;
                if (pv > hi) high_t++;
                @(posedge core_clk);
            end
            pix_valid <= 1'b0;
            nl = (sel == 2'h2) ? 2 : int'(sel);
            for (int l = 1; l <= nl; l++) begin
                len_q.push_back((3 * len + 1) / 2);
                for (int b = 0; b < (3 * len + 1) / 2; b++)
                    px_q.push_back(exp_byte(l, b));
            end
            rows_done <= 1'b1;
            @(posedge core_clk);
            rows_done <= 1'b0;
            repeat (20) @(posedge core_clk);
            // A second pulse while a line is out must be ignored
            rows_done <= 1'b1;
            @(posedge core_clk);
            rows_done <= 1'b0;
            k = 0;
            do begin
                reg_read(emlg_pkg::STATUS_ADDR, 0, 8'h00);
                k++;
            end while (d[0] === 1'b1 && k < 4000);
            check("busy cleared", d[0], 1'b0);
            repeat (4) @(posedge core_clk);
            check("lines left", len_q.size(), 0);
        end
        give_verdict();
    end
endmodule
